// ### rtl/acp_pkg.sv
// Constants and helpers for the ASCII serial command parser
`default_nettype none
package acp_pkg;
	// ----------------------------------------------------------------
	// Characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_AT    = 8'h40;
	localparam logic [7:0] CH_SEMI  = 8'h3B;
	localparam logic [7:0] CH_F     = 8'h46;
	localparam logic [7:0] CH_QRY   = 8'h3F;
	localparam logic [7:0] CH_BANG  = 8'h21;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_LA    = 8'h61;
	localparam logic [7:0] CH_LZ    = 8'h7A;
	localparam logic [7:0] CH_UA    = 8'h41;
	localparam logic [7:0] CH_UZ    = 8'h5A;
	localparam logic [7:0] CASE_OFS = 8'h20;
	localparam logic [23:0] TXT_ACK = 24'h41434B;
	localparam logic [23:0] TXT_NAK = 24'h4E414B;
	localparam logic [15:0] TXT_ON  = 16'h4F4E;
	localparam logic [23:0] TXT_OFF = 24'h4F4646;
	// ----------------------------------------------------------------
	// Command names, upper case, right aligned
	// ----------------------------------------------------------------
	localparam logic [23:0] NM_ADDR = 24'h004144;
	localparam logic [23:0] NM_RATE = 24'h004252;
	localparam logic [23:0] NM_TURN = 24'h525344;
	localparam logic [23:0] NM_ZERO = 24'h564143;
	localparam logic [23:0] NM_ATM  = 24'h41544D;
	// ----------------------------------------------------------------
	// Error codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ERR_NONE  = 8'h00;
	localparam logic [7:0] ERR_ZERO  = 8'h08;
	localparam logic [7:0] ERR_ATM   = 8'h09;
	localparam logic [7:0] ERR_UNREC = 8'hA0;
	localparam logic [7:0] ERR_ARG   = 8'hA9;
	localparam logic [7:0] ERR_RANGE = 8'hAC;
	localparam logic [7:0] ERR_MARK  = 8'hAF;
	localparam logic [7:0] ERR_LOCK  = 8'hB4;
	localparam logic [7:0] ERR_CSA   = 8'hC3;
	localparam logic [7:0] ERR_ONE_DIGIT = 8'h0A;
	// ----------------------------------------------------------------
	// Addresses, rates, framing
	// ----------------------------------------------------------------
	localparam logic [9:0] ADDR_MIN   = 10'h001;
	localparam logic [9:0] ADDR_MAX   = 10'h0FD;
	localparam logic [9:0] ADDR_ECHO  = 10'h0FE;
	localparam logic [9:0] ADDR_QUIET = 10'h0FF;
	localparam logic [7:0] ADDR_FACTORY = 8'hFD;
	localparam logic [2:0] RATE_FACTORY = 3'h1;
	localparam logic       TURN_FACTORY = 1'b1;
	localparam int         NUM_RATES    = 7;
	localparam logic [4:0] TURN_BITS    = 5'h14;
	localparam logic [3:0] UART_STOP    = 4'h9;
	localparam logic [3:0] UART_DONE    = 4'hA;
	localparam logic [3:0] PARAM_MAX    = 4'h8;
	localparam logic [1:0] NAME_MAX     = 2'h3;
	localparam logic [1:0] ADDR_DIGITS  = 2'h3;
	localparam logic [4:0] FRAME_FIXED  = 5'h0A;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CFG  = 12'h004;
	localparam logic [11:0] OFS_STAT = 12'h008;
	localparam int CTRL_LOCK = 0;
	localparam int CTRL_CSA  = 1;
	localparam int CTRL_ZHI  = 2;
	localparam int CTRL_ALO  = 3;
	localparam int CFG_RATE  = 8;
	localparam int CFG_TURN  = 12;
	localparam int ST_CFG    = 0;
	localparam int ST_ZERO   = 1;
	localparam int ST_ATM    = 2;

	typedef enum logic [5:0] {
		P_IDLE = 6'h01, P_ADDR = 6'h02, P_NAME = 6'h04,
		P_PARM = 6'h08, P_T1 = 6'h10, P_T2 = 6'h20
	} acp_pst_t;
	typedef enum logic [2:0] {
		T_IDLE = 3'h1, T_WAIT = 3'h2, T_SEND = 3'h4
	} acp_tst_t;

	function automatic logic [26:0] rate_val(input logic [2:0] i);
		case (i)
			3'h0: rate_val = 27'd4800;
			3'h1: rate_val = 27'd9600;
			3'h2: rate_val = 27'd19200;
			3'h3: rate_val = 27'd38400;
			3'h4: rate_val = 27'd57600;
			3'h5: rate_val = 27'd115200;
			default: rate_val = 27'd230400;
		endcase
	endfunction
endpackage
`default_nettype wire

// ### rtl/acp_parser.sv
// ASCII serial command parser with APB control and status registers
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01: Frames open with @ and end ;FF
// RULE_02: Host query: @ address name ? terminator
// RULE_03: Host command: @ address name ! value terminator
// RULE_04: Names and keywords accepted in any case
// RULE_05: Good message answered with ACK and data
// RULE_06: Faulty message answered NAK code, nothing applied
// RULE_07: Codes 160, 175, 169, 172, 180
// RULE_08: Zero adjust at high pressure gives 8
// RULE_09: Atmosphere adjust at low pressure gives 9
// RULE_10: Code 195 while control setpoint active
// RULE_11: Only seven listed line rates accepted
// RULE_12: Factory line rate is 9600
// RULE_13: Rate switches after reply sent at old rate
// RULE_14: Successful command echoes applied value
// RULE_15: Three digit address, programmable 001 to 253
// RULE_16: Address 254 executes, replies with own address
// RULE_17: Address 255 executes, no reply
// RULE_18: Optional rate dependent reply turnaround delay
// RULE_19: Host transceiver must release line quickly
// RULE_20: Changed settings flagged for non-volatile storage
// RULE_21: Characters are 8 data, no parity, 1 stop
// RULE_22: Only data lines, no flow control
// RULE_23: Foreign addresses ignored silently
// RULE_24: Factory address 253, turnaround delay on
module acp_parser #(
	parameter int CLK_HZ = 200_000_000
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        uart_rxd,
	output logic             uart_txd,
	output logic             tx_drive_en
);
	import acp_pkg::*;

	function automatic logic [23:0] dec3(input logic [7:0] v);
		dec3 = {8'(v / 8'd100) + CH_ZERO, 8'((v / 8'd10) % 8'd10) + CH_ZERO,
			8'(v % 8'd10) + CH_ZERO};
	endfunction
	function automatic logic [47:0] rate_txt(input logic [2:0] i);
		case (i)
			3'h0: rate_txt = 48'h000034383030;
			3'h1: rate_txt = 48'h000039363030;
			3'h2: rate_txt = 48'h003139323030;
			3'h3: rate_txt = 48'h003338343030;
			3'h4: rate_txt = 48'h003537363030;
			3'h5: rate_txt = 48'h313135323030;
			default: rate_txt = 48'h323330343030;
		endcase
	endfunction
	function automatic logic is_digit(input logic [7:0] c);
		is_digit = (c >= CH_ZERO) && (c <= CH_NINE);
	endfunction

	// ----------------------------------------------------------------
	// Settings and line timing
	// ----------------------------------------------------------------
	logic [7:0]  own_addr;
	logic [2:0]  rate_sel;
	logic        turn_on;
	logic        pend_v;
	logic [2:0]  pend_rate;
	logic [3:0]  ctrl;
	logic [2:0]  stat;
	logic [15:0] bitc;
	assign bitc = 16'(CLK_HZ / 32'(rate_val(rate_sel)));

	// ----------------------------------------------------------------
	// Receiver, 8N1, no handshake lines
	// ----------------------------------------------------------------
	logic        rx_busy;
	logic        rx_v;
	logic [15:0] rx_tmr;
	logic [3:0]  rx_bit;
	logic [7:0]  rx_sh;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rx_busy <= 1'b0;
			rx_v    <= 1'b0;
			rx_tmr  <= 16'h0000;
			rx_bit  <= 4'h0;
			rx_sh   <= 8'h00;
		end else begin
			rx_v <= 1'b0;
			if (!rx_busy) begin
				if (!uart_rxd) begin
					rx_busy <= 1'b1;
					rx_tmr  <= bitc >> 1;
					rx_bit  <= 4'h0;
				end
			end else if (rx_tmr != 16'h0000) begin
				rx_tmr <= rx_tmr - 16'h0001;
			end else begin
				rx_tmr <= bitc - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && uart_rxd) begin
					rx_busy <= 1'b0;
				end else if (rx_bit == UART_STOP) begin // RULE_21 RULE_22
					rx_busy <= 1'b0;
					rx_v    <= uart_rxd;
				end else if (rx_bit != 4'h0) begin
					rx_sh <= {uart_rxd, rx_sh[7:1]};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame parser
	// ----------------------------------------------------------------
	acp_pst_t    p_st;
	logic [7:0]  up;
	logic [9:0]  fa;
	logic [1:0]  acnt;
	logic [23:0] name;
	logic [1:0]  nlen;
	logic        nover;
	logic [7:0]  mark;
	logic [63:0] pbuf;
	logic [3:0]  plen;
	logic [26:0] pval;
	logic        pnum;
	logic        pover;
	logic        exec;
	assign up = (rx_sh >= CH_LA && rx_sh <= CH_LZ) ? rx_sh - CASE_OFS : rx_sh; // RULE_04
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			p_st <= P_IDLE;
			fa <= 10'h000;
			acnt <= 2'h0;
			name <= 24'h000000;
			nlen <= 2'h0;
			nover <= 1'b0;
			mark <= 8'h00;
			pbuf <= 64'h0;
			plen <= 4'h0;
			pval <= 27'h0;
			pnum <= 1'b0;
			pover <= 1'b0;
			exec <= 1'b0;
		end else begin
			exec <= 1'b0;
			if (rx_v && rx_sh == CH_AT) begin // RULE_01
				p_st <= P_ADDR;
				fa <= 10'h000;
				acnt <= 2'h0;
				name <= 24'h000000;
				nlen <= 2'h0;
				nover <= 1'b0;
				mark <= 8'h00;
				pbuf <= 64'h0;
				plen <= 4'h0;
				pval <= 27'h0;
				pnum <= 1'b1;
				pover <= 1'b0;
			end else if (rx_v) begin
				unique case (p_st)
					P_IDLE: begin
					end
					P_ADDR: begin
						if (is_digit(rx_sh)) begin // RULE_15
							fa <= 10'(fa * 10'd10 + 10'(rx_sh - CH_ZERO));
							acnt <= acnt + 2'h1;
							if (acnt == ADDR_DIGITS - 2'h1) begin
								p_st <= P_NAME;
							end
						end else begin
							p_st <= P_IDLE;
						end
					end
					P_NAME: begin
						if (rx_sh == CH_SEMI) begin
							p_st <= P_T1;
						end else if (is_digit(up) || (up >= CH_UA && up <= CH_UZ)) begin
							name <= {name[15:0], up};
							if (nlen == NAME_MAX) begin
								nover <= 1'b1;
							end else begin
								nlen <= nlen + 2'h1;
							end
						end else begin
							mark <= rx_sh;
							p_st <= P_PARM;
						end
					end
					P_PARM: begin
						if (rx_sh == CH_SEMI) begin
							p_st <= P_T1;
						end else if (plen == PARAM_MAX) begin
							pover <= 1'b1;
						end else begin
							pbuf <= {pbuf[55:0], up};
							plen <= plen + 4'h1;
							pnum <= pnum & is_digit(rx_sh);
							pval <= 27'(pval * 27'd10 + 27'(rx_sh - CH_ZERO));
						end
					end
					P_T1: begin
						p_st <= (rx_sh == CH_F) ? P_T2 : P_IDLE;
					end
					P_T2: begin
						p_st <= P_IDLE;
						exec <= (rx_sh == CH_F); // RULE_01
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Command decode and answer
	// ----------------------------------------------------------------
	logic        to_me;
	logic        quiet;
	logic        do_exec;
	logic [7:0]  err;
	logic [63:0] n_d;
	logic [3:0]  n_dl;
	logic        ap_addr;
	logic        ap_rate;
	logic        ap_turn;
	logic        turn_new;
	logic        ev_zero;
	logic        ev_atm;
	logic        hit;
	logic [2:0]  hidx;
	acp_tst_t    t_st;
	assign to_me = (fa == {2'b00, own_addr}) || (fa == ADDR_ECHO); // RULE_16 RULE_23
	assign quiet = (fa == ADDR_QUIET); // RULE_17
	assign do_exec = exec && (to_me || quiet) && (t_st == T_IDLE);
	always_comb begin
		err = ERR_NONE;
		n_d = pbuf; // RULE_14
		n_dl = plen;
		ap_addr = 1'b0;
		ap_rate = 1'b0;
		ap_turn = 1'b0;
		turn_new = 1'b0;
		ev_zero = 1'b0;
		ev_atm = 1'b0;
		hit = 1'b0;
		hidx = 3'h0;
		for (int i = 0; i < NUM_RATES; i++) begin
			if (pval == rate_val(3'(i))) begin // RULE_11
				hit = 1'b1;
				hidx = 3'(i);
			end
		end
		if (nover || !(name == NM_ADDR || name == NM_RATE || name == NM_TURN
				|| name == NM_ZERO || name == NM_ATM)) begin
			err = ERR_UNREC; // RULE_07
		end else if (mark == CH_QRY && (name == NM_ZERO || name == NM_ATM)) begin
			err = ERR_MARK;
		end else if (mark == CH_QRY) begin // RULE_05
			if (name == NM_ADDR) begin
				n_d = {40'h0, dec3(own_addr)};
				n_dl = 4'h3;
			end else if (name == NM_RATE) begin
				n_d = {16'h0, rate_txt(rate_sel)};
				n_dl = (rate_sel > 3'h4) ? 4'h6 : (rate_sel > 3'h1) ? 4'h5 : 4'h4;
			end else begin
				n_d = turn_on ? {48'h0, TXT_ON} : {40'h0, TXT_OFF};
				n_dl = turn_on ? 4'h2 : 4'h3;
			end
		end else if (mark != CH_BANG) begin
			err = ERR_MARK; // RULE_07
		end else if (ctrl[CTRL_LOCK]) begin
			err = ERR_LOCK;
		end else if (name == NM_ADDR) begin
			if (!pnum || plen == 4'h0 || pover) begin
				err = ERR_ARG;
			end else if (pval < 27'(ADDR_MIN) || pval > 27'(ADDR_MAX)) begin // RULE_15
				err = ERR_RANGE;
			end else begin
				ap_addr = 1'b1;
			end
		end else if (name == NM_RATE) begin
			if (!pnum || plen == 4'h0 || pover) begin
				err = ERR_ARG;
			end else if (!hit) begin // RULE_11
				err = ERR_RANGE;
			end else begin
				ap_rate = 1'b1;
			end
		end else if (name == NM_TURN) begin // RULE_18
			ap_turn = !pover && ((plen == 4'h2 && pbuf[15:0] == TXT_ON)
				|| (plen == 4'h3 && pbuf[23:0] == TXT_OFF));
			turn_new = (plen == 4'h2);
			err = ap_turn ? ERR_NONE : ERR_ARG;
		end else if (ctrl[CTRL_CSA]) begin
			err = ERR_CSA; // RULE_10
		end else if (name == NM_ZERO) begin
			err = ctrl[CTRL_ZHI] ? ERR_ZERO : ERR_NONE; // RULE_08
			ev_zero = !ctrl[CTRL_ZHI];
		end else begin
			err = ctrl[CTRL_ALO] ? ERR_ATM : ERR_NONE; // RULE_09
			ev_atm = !ctrl[CTRL_ALO];
		end
		if (err != ERR_NONE) begin // RULE_06
			ap_addr = 1'b0;
			ap_rate = 1'b0;
			ap_turn = 1'b0;
			ev_zero = 1'b0;
			ev_atm = 1'b0;
			n_d = (err < ERR_ONE_DIGIT) ? {56'h0, 8'(err + CH_ZERO)} : {40'h0, dec3(err)};
			n_dl = (err < ERR_ONE_DIGIT) ? 4'h1 : 4'h3;
		end
	end

	// ----------------------------------------------------------------
	// Settings; software restores them from storage after power-up
	// ----------------------------------------------------------------
	logic apb_wr;
	logic t_done;
	assign apb_wr = psel && penable && pwrite && pready;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			own_addr <= ADDR_FACTORY; // RULE_24
			rate_sel <= RATE_FACTORY; // RULE_12
			turn_on <= TURN_FACTORY;
			pend_v <= 1'b0;
			pend_rate <= RATE_FACTORY;
		end else begin
			if (apb_wr && paddr == OFS_CFG) begin
				own_addr <= pwdata[7:0];
				rate_sel <= (pwdata[CFG_RATE+:3] < 3'(NUM_RATES)) ? pwdata[CFG_RATE+:3] : rate_sel;
				turn_on <= pwdata[CFG_TURN];
			end
			if (do_exec && ap_addr) begin
				own_addr <= pval[7:0];
			end
			if (do_exec && ap_turn) begin
				turn_on <= turn_new;
			end
			// Old rate kept until the reply has left the line
			if (do_exec && ap_rate && quiet) begin
				rate_sel <= hidx;
			end else if (do_exec && ap_rate) begin // RULE_13
				pend_v <= 1'b1;
				pend_rate <= hidx;
			end else if (t_done && pend_v) begin
				rate_sel <= pend_rate; // RULE_13
				pend_v <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave, one wait-free access phase
	// ----------------------------------------------------------------
	logic [2:0] st_set;
	assign st_set = {do_exec && ev_atm, do_exec && ev_zero,
		do_exec && (ap_addr || ap_rate || ap_turn)};
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl <= 4'h0;
			stat <= 3'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable
				&& !(paddr == OFS_CTRL || paddr == OFS_CFG || paddr == OFS_STAT);
			unique case (paddr)
				OFS_CTRL: prdata <= {28'h0, ctrl};
				OFS_CFG: prdata <= {19'h0, turn_on, 1'b0, rate_sel, own_addr};
				OFS_STAT: prdata <= {29'h0, stat};
				default: prdata <= 32'h00000000;
			endcase
			if (apb_wr && paddr == OFS_CTRL) begin
				ctrl <= pwdata[3:0];
			end
			// Set wins over a clear in the same cycle
			stat <= (stat & ~((apb_wr && paddr == OFS_STAT) ? pwdata[2:0] : 3'h0))
				| st_set; // RULE_20
		end
	end

	// ----------------------------------------------------------------
	// Reply transmitter
	// ----------------------------------------------------------------
	logic        r_ack;
	logic [63:0] r_d;
	logic [3:0]  r_dl;
	logic [23:0] r_adr;
	logic [4:0]  tidx;
	logic [4:0]  tbit;
	logic [15:0] ttmr;
	logic [7:0]  cur;
	logic [4:0]  dk;
	always_comb begin
		dk = 5'(tidx - 5'h07);
		if (tidx == 5'h00) begin
			cur = CH_AT;
		end else if (tidx < 5'h04) begin
			cur = r_adr[8*(3-tidx)+:8];
		end else if (tidx < 5'h07) begin
			cur = r_ack ? TXT_ACK[8*(6-tidx)+:8] : TXT_NAK[8*(6-tidx)+:8];
		end else if (dk < 5'(r_dl)) begin
			cur = r_d[8*(5'(r_dl)-5'h01-dk)+:8];
		end else begin
			cur = (dk == 5'(r_dl)) ? CH_SEMI : CH_F; // RULE_01
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			t_st <= T_IDLE;
			uart_txd <= 1'b1;
			tx_drive_en <= 1'b0;
			t_done <= 1'b0;
			r_ack <= 1'b0;
			r_d <= 64'h0;
			r_dl <= 4'h0;
			r_adr <= 24'h000000;
			tidx <= 5'h00;
			tbit <= 5'h00;
			ttmr <= 16'h0000;
		end else begin
			t_done <= 1'b0;
			unique case (t_st)
				T_IDLE: begin
					if (do_exec && to_me) begin // RULE_16
						r_ack <= (err == ERR_NONE);
						r_d <= n_d;
						r_dl <= n_dl;
						r_adr <= dec3(own_addr);
						tidx <= 5'h00;
						tbit <= 5'h00;
						ttmr <= turn_on ? bitc - 16'h0001 : 16'h0000;
						t_st <= turn_on ? T_WAIT : T_SEND; // RULE_18
					end
				end
				T_WAIT: begin
					// Gives a slow host transceiver time to turn round
					if (ttmr != 16'h0000) begin
						ttmr <= ttmr - 16'h0001;
					end else if (tbit == TURN_BITS - 5'h01) begin // RULE_19
						tbit <= 5'h00;
						t_st <= T_SEND;
					end else begin
						tbit <= tbit + 5'h01;
						ttmr <= bitc - 16'h0001;
					end
				end
				T_SEND: begin
					if (ttmr != 16'h0000) begin
						ttmr <= ttmr - 16'h0001;
					end else begin
						ttmr <= bitc - 16'h0001;
						tx_drive_en <= 1'b1;
						if (tbit == 5'(UART_DONE)) begin
							if (tidx == FRAME_FIXED + 5'(r_dl) - 5'h01) begin
								tx_drive_en <= 1'b0;
								t_done <= 1'b1;
								t_st <= T_IDLE;
							end else begin
								tidx <= tidx + 5'h01;
								uart_txd <= 1'b0;
								tbit <= 5'h01;
							end
						end else begin
							uart_txd <= (tbit == 5'h00) ? 1'b0 : // RULE_21
								(tbit == 5'(UART_STOP)) ? 1'b1 : cur[3'(tbit - 5'h01)];
							tbit <= tbit + 5'h01;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verif/acp_sva.sv
// Checker on the parser's bus and serial ports
`timescale 1ns/10ps
`default_nettype none
module acp_sva #(
	parameter int CLK_HZ = 200_000_000
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        uart_rxd,
	input wire logic        uart_txd,
	input wire logic        tx_drive_en
);
	import acp_pkg::*;
	logic mapped;
	assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CFG) || (paddr == OFS_STAT);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// Bus
	// ----------------------------------------------------------------
	sequence setup_s; psel && !penable; endsequence
	sequence answer_s; pready ##1 !pready; endsequence
	a_setup_answer: assert property (setup_s |=> answer_s)
		else $error("pready not one cycle after setup");
	a_idle_silent: assert property (!psel |=> !pready)
		else $error("pready without a transfer");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// ----------------------------------------------------------------
	// Serial line
	// ----------------------------------------------------------------
	a_line_idle: assert property (!tx_drive_en |-> uart_txd)
		else $error("line low while driver off");
	a_start_driven: assert property ($fell(uart_txd) |-> tx_drive_en)
		else $error("start bit without driver");
	a_start_len: assert property ($fell(uart_txd) |=> !uart_txd [*3])
		else $error("start bit too short");
	a_drive_hold: assert property ($fell(tx_drive_en) |-> $past(uart_txd))
		else $error("driver released before stop level");
endmodule
bind acp_parser acp_sva #(.CLK_HZ(CLK_HZ)) i_acp_sva (.sys_clk, .nrst, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .uart_rxd, .uart_txd,
	.tx_drive_en);
`default_nettype wire

// ### verif/acp_host.sv
// Host model on the serial line
`timescale 1ns/10ps
`default_nettype none
module acp_host (
	input  wire logic sys_clk,
	input  wire logic uart_txd,
	output logic      uart_rxd
);
	int unsigned bit_cyc = 8;
	string       rx_text = "";
	longint      cyc = 0;
	longint      last_end = 0;
	longint      first_start = 0;
	logic [7:0]  b;
	// Only the data line is driven, idle high between characters
	initial uart_rxd = 1'b1;
	always @(posedge sys_clk) cyc <= cyc + 1;
	// One start, eight data lsb first, one stop, no parity
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			uart_rxd <= f[i];
			repeat (bit_cyc) @(posedge sys_clk);
		end
	endtask
	// Caller forms the whole frame and waits for the reply before the next
	task automatic send_text(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_byte(s[i]);
		end
		last_end = cyc;
	endtask
	// Receiver samples mid bit; a bad stop level garbles the text on purpose
	initial forever begin
		@(negedge uart_txd);
		if (rx_text.len() == 0) begin
			first_start = cyc;
		end
		repeat (bit_cyc / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge sys_clk);
			b[i] = uart_txd;
		end
		repeat (bit_cyc) @(posedge sys_clk);
		rx_text = {rx_text, (uart_txd === 1'b1) ? string'(b) : "#"};
	end
endmodule
`default_nettype wire

// ### verif/tb_acp_parser.sv
// Self-checking bench for the ASCII serial command parser
`timescale 1ns/10ps
`default_nettype none
module tb_acp_parser;
	import acp_pkg::*;
	typedef struct { logic [3:0] ctrl; string cmd; string exp; } acp_row_t;
	localparam int HZ = 76800;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        uart_rxd;
	logic        uart_txd;
	logic        tx_drive_en;
	logic [31:0] rd;
	logic        er;
	longint      gap;
	int          err_count = 0;
	int          check_count = 0;
	acp_row_t rows [] = '{
		'{4'h0, "@253RSD?;FF", "@253ACKON;FF"},
		'{4'h0, "@253br?;FF", "@253ACK9600;FF"},
		'{4'h0, "@254AD?;FF", "@253ACK253;FF"},
		'{4'h0, "@253XYZ?;FF", "@253NAK160;FF"},
		'{4'h0, "@253AD#;FF", "@253NAK175;FF"},
		'{4'h0, "@253AD!12A;FF", "@253NAK169;FF"},
		'{4'h0, "@253AD!254;FF", "@253NAK172;FF"},
		'{4'h0, "@253BR!1200;FF", "@253NAK172;FF"},
		'{4'h0, "@253RSD!YES;FF", "@253NAK169;FF"},
		'{4'h0, "@252RSD?;FF", ""},
		'{4'h0, "@255RSD!OFF;FF", ""},
		'{4'h0, "@253RSD?;FF", "@253ACKOFF;FF"},
		'{4'h1, "@253RSD!ON;FF", "@253NAK180;FF"},
		'{4'h2, "@253VAC!;FF", "@253NAK195;FF"},
		'{4'h4, "@253VAC!;FF", "@253NAK8;FF"},
		'{4'h8, "@253ATM!7.60;FF", "@253NAK9;FF"},
		'{4'h0, "xx@253ATM!7.60;FF", "@253ACK7.60;FF"},
		'{4'h0, "@253rsd!on;FF", "@253ACKON;FF"}
	};
	always #2.5 sys_clk = ~sys_clk;
	acp_parser #(.CLK_HZ(HZ)) i_acp_parser (.sys_clk, .nrst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .uart_rxd, .uart_txd, .tx_drive_en);
	acp_host i_acp_host (.sys_clk, .uart_txd, .uart_rxd);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Entered just after a rising edge; request held until pready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("ERROR %0t apb no pready", $time);
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never drives psel twice at once
		@(posedge sys_clk);
	endtask
	// Tail wait also proves silence for frames that expect no reply
	task automatic frame(input string cmd, input string exp);
		int n;
		i_acp_host.rx_text = "";
		i_acp_host.send_text(cmd);
		n = 0;
		while (i_acp_host.rx_text.len() < exp.len() && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		// Outlasts the turnaround delay plus one character
		repeat (32 * i_acp_host.bit_cyc) @(posedge sys_clk);
		check_count++;
		if (n >= 3000 || i_acp_host.rx_text != exp) begin
			err_count++;
			$display("ERROR %0t %s replied %s", $time, cmd, i_acp_host.rx_text);
			if (n >= 3000) begin
				stop_test();
			end
		end
		$display("test %s done", cmd);
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			apb(1'b1, OFS_CTRL, {28'h0, rows[i].ctrl});
			frame(rows[i].cmd, rows[i].exp);
		end
		frame("@253RSD?;FF", "@253ACKON;FF");
		gap = i_acp_host.first_start - i_acp_host.last_end;
		chk({31'h0, gap >= 150 && gap <= 170}, 32'h1, "delay on");
		frame("@253RSD!OFF;FF", "@253ACKOFF;FF");
		frame("@253RSD?;FF", "@253ACKOFF;FF");
		gap = i_acp_host.first_start - i_acp_host.last_end;
		chk({31'h0, gap < 8}, 32'h1, "delay off");
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h5, "status");
		apb(1'b1, OFS_STAT, 32'h5);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h0, "status clear");
		apb(1'b0, OFS_CFG, 32'h0);
		chk(rd, 32'h000001FD, "cfg");
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		apb(1'b0, 12'h00C, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000, "unmapped");
		$display("test registers done");
		frame("@253BR!19200;FF", "@253ACK19200;FF");
		i_acp_host.bit_cyc = 4;
		frame("@253BR?;FF", "@253ACK19200;FF");
		frame("@253AD!007;FF", "@253ACK007;FF");
		frame("@007AD?;FF", "@007ACK007;FF");
		nrst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		i_acp_host.bit_cyc = 8;
		@(posedge sys_clk);
		apb(1'b0, OFS_CFG, 32'h0);
		chk(rd, 32'h000011FD, "factory cfg");
		frame("@253RSD?;FF", "@253ACKON;FF");
		stop_test();
	end
endmodule
`default_nettype wire
